// *** include/cc_timer_pkg.sv ***
// Shared constants for the two-channel capture/compare timer.
package cc_timer_pkg;
   // Register byte offsets on the AHB-Lite bus.
   localparam logic [7:0] ctrl_status_off = 8'h00;
   localparam logic [7:0] counter_off = 8'h04;
   localparam logic [7:0] modulo_off = 8'h08;
   localparam logic [7:0] chan0_ctrl_status_off = 8'h0C;
   localparam logic [7:0] chan0_value_off = 8'h10;
   localparam logic [7:0] chan1_ctrl_status_off = 8'h14;
   localparam logic [7:0] chan1_value_off = 8'h18;
   // Timer control/status field positions.
   localparam int prescale_lsb = 0;
   localparam int reset_bit = 4;
   localparam int stop_bit = 5;
   localparam int overflow_irq_enable_bit = 6;
   localparam int overflow_flag_bit = 7;
   // Channel control/status field positions.
   localparam int edge_level_sel_lo_bit = 0;
   localparam int edge_level_sel_hi_bit = 1;
   localparam int toggle_on_overflow_bit = 2;
   localparam int mode_sel_lo_bit = 3;
   localparam int buffered_link_select_bit = 4;
   localparam int chan_irq_enable_bit = 6;
   localparam int chan_event_flag_bit = 7;
   // Values after reset.
   localparam logic [15:0] modulo_reset = 16'hFFFF;
   localparam logic [7:0] ctrl_status_reset = 8'h20;
   // Capture latency in bus cycles from the synchronised pin edge.
   localparam int capture_latency = 2;
endpackage

// *** rtl/cc_timer.sv ***
// Two-channel capture/compare timer with an AHB-Lite register slave.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
// How it works
// - 16-bit up-counter, free or modulo.
// - Counter reads never disturb counting.
// - Three-bit select picks seven prescaled rates.
// - Each channel independently capture or compare.
// - Edge bits choose rising, falling, either.
// - Active edge copies counter into channel.
// - Capture overwrites regardless of flag.
// - Captured value appears two cycles after edge.
// - Channel flag requests interrupt when enabled.
// - Reset leaves channel values unchanged.
// - Compare match sets, clears or toggles pin.
// - Compare match raises interrupt via flag.
// - Unbuffered writes replace compare value immediately.
// - Link bit joins channels onto channel 0 pin.
// - Channel 0 value governs first when linked.
// - Overflow hands control to last-written pair.
// - Linked mode frees channel 1 pin and interrupt.
// - Per-channel toggle on overflow option.
// - Stop bit halts, reset bit clears counter.
// - Overflow flag at modulo, interrupt when enabled.
module cc_timer #(
   parameter int chan_count = 2
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Channel pins.
   input wire logic chan0_pin_in,
   input wire logic chan1_pin_in,
   output logic chan0_pin_out,
   output logic chan0_pin_oe,
   output logic chan1_pin_out,
   output logic chan1_pin_oe,
   // Interrupt requests.
   output logic overflow_irq,
   output logic chan0_irq,
   output logic chan1_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Bus slave.
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [7:0] rd_addr;
   logic rd_take;
   logic [7:0] ctrl_q;
   logic [15:0] count_q;
   logic [15:0] modulo_q;
   logic [7:0] chan_ctrl_q [chan_count];
   logic [15:0] chan_val_q [chan_count];
   logic [chan_count-1:0] flag_seen_q;
   logic [chan_count-1:0] chan_set;
   logic [chan_count-1:0] val_wr;
   logic [chan_count-1:0] ctl_wr;
   logic overflow_set;
   logic tick;
   logic linked;
   logic active_q;
   logic pend_q;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   assign rd_addr = haddr[7:0];
   assign linked = chan_ctrl_q[0][cc_timer_pkg::buffered_link_select_bit];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else if (hready) begin
         wr_pend_q <= hsel && htrans[1] && hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   // Reads come from live state; a counter read has no side effect.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_take) begin
         case (rd_addr)
            cc_timer_pkg::ctrl_status_off: hrdata <= {24'h000000, ctrl_q};
            cc_timer_pkg::counter_off: hrdata <= {16'h0000, count_q};
            cc_timer_pkg::modulo_off: hrdata <= {16'h0000, modulo_q};
            cc_timer_pkg::chan0_ctrl_status_off: hrdata <= {24'h000000, chan_ctrl_q[0]};
            cc_timer_pkg::chan0_value_off: hrdata <= {16'h0000, chan_val_q[0]};
            cc_timer_pkg::chan1_ctrl_status_off: hrdata <= {24'h000000, chan_ctrl_q[1]};
            cc_timer_pkg::chan1_value_off: hrdata <= {16'h0000, chan_val_q[1]};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timer control and status.
   logic ctrl_wr;
   assign ctrl_wr = wr_pend_q && wr_addr_q == cc_timer_pkg::ctrl_status_off;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= cc_timer_pkg::ctrl_status_reset;
      end else begin
         if (ctrl_wr) begin
            ctrl_q[6:0] <= hwdata[6:0];
            ctrl_q[cc_timer_pkg::reset_bit] <= 1'b0;
            if (!hwdata[cc_timer_pkg::overflow_flag_bit]) begin
               ctrl_q[cc_timer_pkg::overflow_flag_bit] <= 1'b0;
            end
         end
         if (overflow_set) begin
            ctrl_q[cc_timer_pkg::overflow_flag_bit] <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         modulo_q <= cc_timer_pkg::modulo_reset;
      end else if (wr_pend_q && wr_addr_q == cc_timer_pkg::modulo_off) begin
         modulo_q <= hwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Prescaler and counter.
   logic [6:0] pre_q;
   logic [2:0] psel;
   assign psel = ctrl_q[cc_timer_pkg::prescale_lsb +: 3];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_q <= 7'h00;
      end else if (ctrl_wr && hwdata[cc_timer_pkg::reset_bit]) begin
         pre_q <= 7'h00;
      end else if (!ctrl_q[cc_timer_pkg::stop_bit]) begin
         pre_q <= pre_q + 7'h01;
      end
   end

   // Divide by 1, 2, 4 ... 64; select values 7 behave as 6.
   always_comb begin
      case (psel)
         3'h0: tick = 1'b1;
         3'h1: tick = pre_q[0];
         3'h2: tick = &pre_q[1:0];
         3'h3: tick = &pre_q[2:0];
         3'h4: tick = &pre_q[3:0];
         3'h5: tick = &pre_q[4:0];
         3'h6: tick = &pre_q[5:0];
         default: tick = &pre_q[5:0];
      endcase
      tick = tick && !ctrl_q[cc_timer_pkg::stop_bit];
   end

   assign overflow_set = tick && count_q == modulo_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= 16'h0000;
      end else if (ctrl_wr && hwdata[cc_timer_pkg::reset_bit]) begin
         count_q <= 16'h0000;
      end else if (overflow_set) begin
         count_q <= 16'h0000;
      end else if (tick) begin
         count_q <= count_q + 16'h0001;
      end
   end

   assign overflow_irq = ctrl_q[cc_timer_pkg::overflow_flag_bit]
      && ctrl_q[cc_timer_pkg::overflow_irq_enable_bit];

   ////////////////////////////////////////////////////////////////////////
   // Channels.
   logic [2:0] pin_sync_q [chan_count];
   logic [15:0] snap_q [chan_count];
   logic [chan_count-1:0] cap_pend_q;
   logic [chan_count-1:0] pin_q;
   logic [chan_count-1:0] match;

   // Buffered pair: active_q picks the pair that drives channel 0.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active_q <= 1'b0;
         pend_q <= 1'b0;
      end else if (!linked) begin
         active_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         if (val_wr[1]) begin
            pend_q <= 1'b1;
         end else if (val_wr[0]) begin
            pend_q <= 1'b0;
         end
         if (overflow_set) begin
            active_q <= val_wr[1] ? 1'b1 : (val_wr[0] ? 1'b0 : pend_q);
         end
      end
   end

   for (genvar c = 0; c < chan_count; c++) begin : g_chan
      logic [7:0] cc;
      logic capture_mode;
      logic compare_mode;
      logic rise;
      logic fall;
      logic edge_hit;
      logic [15:0] cmp_val;
      logic own_match;
      logic pin_in;

      assign pin_in = (c == 0) ? chan0_pin_in : chan1_pin_in;
      assign cc = (c == 1 && linked) ? 8'h00 : chan_ctrl_q[c];
      assign capture_mode = cc[1:0] != 2'b00 && !cc[cc_timer_pkg::mode_sel_lo_bit]
         && !cc[cc_timer_pkg::buffered_link_select_bit];
      assign compare_mode = cc[1:0] != 2'b00 && !capture_mode;
      assign val_wr[c] = wr_pend_q && wr_addr_q == 8'(cc_timer_pkg::chan0_value_off + 8'(8 * c));
      assign ctl_wr[c] = wr_pend_q && wr_addr_q == 8'(cc_timer_pkg::chan0_ctrl_status_off + 8'(8 * c));
      assign rise = pin_sync_q[c][1] && !pin_sync_q[c][2];
      assign fall = !pin_sync_q[c][1] && pin_sync_q[c][2];
      assign edge_hit = capture_mode && ((cc[cc_timer_pkg::edge_level_sel_lo_bit] && rise)
         || (cc[cc_timer_pkg::edge_level_sel_hi_bit] && fall));
      assign cmp_val = (c == 0 && linked && active_q) ? chan_val_q[1] : chan_val_q[c];
      assign own_match = compare_mode && tick && count_q == cmp_val;
      assign match[c] = own_match;
      assign chan_set[c] = own_match || cap_pend_q[c];

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pin_sync_q[c] <= 3'b000;
         end else begin
            pin_sync_q[c] <= {pin_sync_q[c][1:0], pin_in};
         end
      end

      // Edge snapshot then write: value lands two cycles after the edge.
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cap_pend_q[c] <= 1'b0;
            snap_q[c] <= 16'h0000;
         end else begin
            cap_pend_q[c] <= edge_hit;
            if (edge_hit) begin
               snap_q[c] <= count_q;
            end
         end
      end

      // No reset: values survive system reset.
      always_ff @(posedge hclk) begin
         if (cap_pend_q[c]) begin
            chan_val_q[c] <= snap_q[c];
         end else if (val_wr[c]) begin
            chan_val_q[c] <= hwdata[15:0];
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            chan_ctrl_q[c] <= 8'h00;
            flag_seen_q[c] <= 1'b0;
         end else begin
            if (rd_take && rd_addr == 8'(cc_timer_pkg::chan0_ctrl_status_off + 8'(8 * c))) begin
               flag_seen_q[c] <= chan_ctrl_q[c][cc_timer_pkg::chan_event_flag_bit];
            end
            if (ctl_wr[c] && !(c == 1 && linked)) begin
               chan_ctrl_q[c][6:0] <= (c == 0) ? hwdata[6:0] : {hwdata[6:5], 1'b0, hwdata[3:0]};
               if (!hwdata[cc_timer_pkg::chan_event_flag_bit] && flag_seen_q[c]) begin
                  chan_ctrl_q[c][cc_timer_pkg::chan_event_flag_bit] <= 1'b0;
                  flag_seen_q[c] <= 1'b0;
               end
            end
            if (chan_set[c]) begin
               chan_ctrl_q[c][cc_timer_pkg::chan_event_flag_bit] <= 1'b1;
            end
         end
      end

      // Overflow toggle wins over a simultaneous match.
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pin_q[c] <= 1'b0;
         end else if (compare_mode && overflow_set && cc[cc_timer_pkg::toggle_on_overflow_bit]) begin
            pin_q[c] <= !pin_q[c];
         end else if (own_match) begin
            case (cc[1:0])
               2'b01: pin_q[c] <= !pin_q[c];
               2'b10: pin_q[c] <= 1'b0;
               2'b11: pin_q[c] <= 1'b1;
               default: pin_q[c] <= pin_q[c];
            endcase
         end
      end
   end

   assign chan0_pin_out = pin_q[0];
   assign chan1_pin_out = pin_q[1];
   assign chan0_pin_oe = g_chan[0].compare_mode;
   assign chan1_pin_oe = g_chan[1].compare_mode;
   assign chan0_irq = chan_ctrl_q[0][cc_timer_pkg::chan_event_flag_bit]
      && chan_ctrl_q[0][cc_timer_pkg::chan_irq_enable_bit];
   assign chan1_irq = chan_ctrl_q[1][cc_timer_pkg::chan_event_flag_bit]
      && chan_ctrl_q[1][cc_timer_pkg::chan_irq_enable_bit] && !linked;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   // Cycles since the last counter tick while the counter runs.
   logic [6:0] tick_gap_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_gap_q <= 7'h00;
      end else if (tick || ctrl_q[cc_timer_pkg::stop_bit] || ctrl_wr) begin
         tick_gap_q <= 7'h00;
      end else begin
         tick_gap_q <= tick_gap_q + 7'h01;
      end
   end

   count_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      overflow_set && !ctrl_wr |=> count_q == 16'h0000) else $error("counter did not wrap");
   count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tick && !overflow_set && !ctrl_wr |=> count_q == $past(count_q) + 16'h0001)
      else $error("counter did not step");
   stop_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl_q[cc_timer_pkg::stop_bit] && !ctrl_wr |=> $stable(count_q)) else $error("stopped counter moved");
   tick_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tick_gap_q < 7'h40) else $error("prescaled tick missing");
   capture_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
      g_chan[0].edge_hit |-> ##2 chan_val_q[0] == $past(count_q, 2)) else $error("capture value wrong");
   ovf_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      overflow_set |=> ctrl_q[cc_timer_pkg::overflow_flag_bit]) else $error("overflow flag missing");
   ovf_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !ctrl_q[cc_timer_pkg::overflow_irq_enable_bit] |-> !overflow_irq) else $error("masked overflow irq");
   chan_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      chan_set[0] |=> chan_ctrl_q[0][cc_timer_pkg::chan_event_flag_bit]) else $error("channel flag missing");
   chan1_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      chan_set[1] |=> chan_ctrl_q[1][cc_timer_pkg::chan_event_flag_bit]) else $error("channel 1 flag missing");
   irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !chan_ctrl_q[0][cc_timer_pkg::chan_irq_enable_bit] |-> !chan0_irq) else $error("masked irq raised");
   link_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
      linked |-> !chan1_pin_oe && !chan1_irq) else $error("channel 1 not released");
   set_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
      match[0] && !overflow_set && chan_ctrl_q[0][1:0] == 2'b11 |=> chan0_pin_out) else $error("set failed");
   clear_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
      match[1] && !overflow_set && chan_ctrl_q[1][1:0] == 2'b10 |=> !chan1_pin_out) else $error("clear failed");
   ovf_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      g_chan[1].compare_mode && overflow_set && g_chan[1].cc[cc_timer_pkg::toggle_on_overflow_bit]
      |=> chan1_pin_out != $past(chan1_pin_out)) else $error("overflow toggle missing");
   swap_new_a: assert property (@(posedge hclk) disable iff (!hresetn)
      linked && overflow_set && pend_q && !val_wr[0] |=> active_q) else $error("buffered swap missed");
   swap_back_a: assert property (@(posedge hclk) disable iff (!hresetn)
      linked && overflow_set && !val_wr[1] && !pend_q |=> !active_q) else $error("buffered return missed");
   swap_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      linked && !overflow_set |=> $stable(active_q)) else $error("active pair moved early");
   capture_c: cover property (@(posedge hclk) disable iff (!hresetn) cap_pend_q[0]);
   match_c: cover property (@(posedge hclk) disable iff (!hresetn) match[0]);
   swap_c: cover property (@(posedge hclk) disable iff (!hresetn) linked && $rose(active_q));
   wrap_c: cover property (@(posedge hclk) disable iff (!hresetn) linked && overflow_set);
endmodule

// *** verif/pin_partner.sv ***
// External signal sources that sit on the two channel pins.
`timescale 1ns/1ns
module pin_partner (
   // Clock.
   input wire logic hclk,
   // Pin drive from the timer.
   input wire logic pin0_out,
   input wire logic pin0_oe,
   input wire logic pin1_out,
   input wire logic pin1_oe,
   // Resolved pin levels.
   output logic pin0_in,
   output logic pin1_in
);
   logic ext0_q = 1'b0;
   logic ext1_q = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // The timer wins the wire while it drives the pin.
   assign pin0_in = pin0_oe ? pin0_out : ext0_q;
   assign pin1_in = pin1_oe ? pin1_out : ext1_q;
   ////////////////////////////////////////////////////////////////////////
   // Sets the outside level of one pin just after a rising edge.
   task automatic drive(input int ch, input logic v);
      @(posedge hclk);
      if (ch == 0) begin
         ext0_q <= v;
      end else begin
         ext1_q <= v;
      end
   endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the capture/compare timer.
`timescale 1ns/1ns
module testbench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata;
   logic hreadyout, hresp, p0_in, p1_in, p0_out, p0_oe, p1_out, p1_oe, ov_irq, c0_irq, c1_irq;
   logic [31:0] d, c1;
   int err_total = 0;
   int checks_done = 0;
   always #4 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////////
   cc_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .chan0_pin_in(p0_in), .chan1_pin_in(p1_in),
      .chan0_pin_out(p0_out), .chan0_pin_oe(p0_oe), .chan1_pin_out(p1_out), .chan1_pin_oe(p1_oe),
      .overflow_irq(ov_irq), .chan0_irq(c0_irq), .chan1_irq(c1_irq));
   pin_partner i_pins (.hclk(hclk), .pin0_out(p0_out), .pin0_oe(p0_oe), .pin1_out(p1_out),
      .pin1_oe(p1_oe), .pin0_in(p0_in), .pin1_in(p1_in));
   ////////////////////////////////////////////////////////////////////////
   // One AHB-Lite single transfer; entered just after a rising edge.
   task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h000000, off};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wr ? wd : 32'h00000000;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] off, input logic [31:0] wd);
      logic [31:0] x;
      xfer(1'b1, off, wd, x);
   endtask
   task automatic rd(input logic [7:0] off, output logic [31:0] v);
      xfer(1'b0, off, 32'h00000000, v);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge hclk);
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rd(cc_timer_pkg::ctrl_status_off, d);
      chk(d, 32'h00000020);
      rd(cc_timer_pkg::modulo_off, d);
      chk(d, 32'h0000FFFF);
      rd(8'h40, d);
      chk(d, 32'h00000000);
      chk({31'h0, hresp}, 32'h00000000);
      // Free run at full rate: back-to-back reads see the count step by two.
      wr(cc_timer_pkg::ctrl_status_off, 32'h00000000);
      rd(cc_timer_pkg::counter_off, c1);
      rd(cc_timer_pkg::counter_off, d);
      chk(d - c1, 32'h00000002);
      // Slowest prescale for 640 bus cycles gives ten counts.
      wr(cc_timer_pkg::ctrl_status_off, 32'h00000036);
      wr(cc_timer_pkg::ctrl_status_off, 32'h00000006);
      repeat (640) @(posedge hclk);
      wr(cc_timer_pkg::ctrl_status_off, 32'h00000026);
      rd(cc_timer_pkg::counter_off, c1);
      chk(c1, 32'h0000000A);
      // Capture against every edge code and both pin directions.
      for (int code = 1; code <= 3; code++) begin
         for (int p = 0; p <= 1; p++) begin
            rd(cc_timer_pkg::chan0_ctrl_status_off, d);
            wr(cc_timer_pkg::chan0_ctrl_status_off, 32'h00000000);
            i_pins.drive(0, p[0]);
            repeat (6) @(posedge hclk);
            wr(cc_timer_pkg::chan0_value_off, 32'h00001234);
            wr(cc_timer_pkg::chan0_ctrl_status_off, 32'h40 | code);
            i_pins.drive(0, ~p[0]);
            repeat (8) @(posedge hclk);
            rd(cc_timer_pkg::chan0_value_off, d);
            if (code[p] === 1'b1) begin
               chk(d, c1);
               chk({31'h0, c0_irq}, 32'h00000001);
            end else begin
               chk(d, 32'h00001234);
               chk({31'h0, c0_irq}, 32'h00000000);
            end
         end
      end
      // Compare on channel 1 with a short modulo period of ten counts.
      wr(cc_timer_pkg::ctrl_status_off, 32'h00000030);
      wr(cc_timer_pkg::modulo_off, 32'h00000009);
      wr(cc_timer_pkg::chan1_value_off, 32'h00000005);
      wr(cc_timer_pkg::chan1_ctrl_status_off, 32'h0000004B);
      wr(cc_timer_pkg::ctrl_status_off, 32'h00000040);
      repeat (40) @(posedge hclk);
      chk({30'h0, p1_oe, p1_out}, 32'h00000003);
      chk({30'h0, c1_irq, ov_irq}, 32'h00000003);
      rd(cc_timer_pkg::counter_off, d);
      chk(32'(d <= 9), 32'h00000001);
      wr(cc_timer_pkg::chan1_ctrl_status_off, 32'h0000000A);
      repeat (40) @(posedge hclk);
      chk({31'h0, p1_out}, 32'h00000000);
      wr(cc_timer_pkg::chan1_ctrl_status_off, 32'h00000009);
      repeat (30) @(posedge hclk);
      c1 = {31'h0, p1_out};
      repeat (10) @(posedge hclk);
      chk({31'h0, p1_out}, c1 ^ 32'h00000001);
      // A smaller value written just after the compare event keeps one action a period.
      c1 = {31'h0, p1_out};
      while (p1_out === c1[0]) @(posedge hclk);
      wr(cc_timer_pkg::chan1_value_off, 32'h00000002);
      repeat (20) @(posedge hclk);
      c1 = {31'h0, p1_out};
      repeat (10) @(posedge hclk);
      chk({31'h0, p1_out}, c1 ^ 32'h00000001);
      // Toggle on overflow with a compare value the counter never reaches.
      wr(cc_timer_pkg::chan1_value_off, 32'h00000020);
      wr(cc_timer_pkg::chan1_ctrl_status_off, 32'h0000000E);
      repeat (25) @(posedge hclk);
      c1 = {31'h0, p1_out};
      repeat (10) @(posedge hclk);
      chk({31'h0, p1_out}, c1 ^ 32'h00000001);
      // Linked pair: channel 0 value governs and channel 1 is let go.
      wr(cc_timer_pkg::chan0_value_off, 32'h00000003);
      wr(cc_timer_pkg::chan0_ctrl_status_off, 32'h0000001B);
      wr(cc_timer_pkg::chan1_ctrl_status_off, 32'h00000000);
      repeat (40) @(posedge hclk);
      chk({30'h0, p0_oe, p0_out}, 32'h00000003);
      chk({31'h0, p1_oe}, 32'h00000000);
      rd(cc_timer_pkg::chan1_ctrl_status_off, d);
      chk(d & 32'h0000003F, 32'h0000000E);
      // Toggle on compare: the driving pair changes only at overflow.
      wr(cc_timer_pkg::chan0_ctrl_status_off, 32'h00000019);
      wr(cc_timer_pkg::chan1_value_off, 32'h00000020);
      repeat (20) @(posedge hclk);
      c1 = {31'h0, p0_out};
      repeat (10) @(posedge hclk);
      chk({31'h0, p0_out}, c1);
      wr(cc_timer_pkg::chan0_value_off, 32'h00000005);
      repeat (20) @(posedge hclk);
      c1 = {31'h0, p0_out};
      repeat (10) @(posedge hclk);
      chk({31'h0, p0_out}, c1 ^ 32'h00000001);
      // A second reset leaves the channel values alone.
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(cc_timer_pkg::chan1_value_off, d);
      chk(d, 32'h00000020);
      rd(cc_timer_pkg::ctrl_status_off, d);
      chk(d, 32'h00000020);
      end_of_test();
   end
endmodule
